// ### tb/spt_tester.sv
`timescale 1ns/100ps
// ===========================================================
// board tester: drives the pci pins and the power-down pin
module spt_tester import spt_pkg::*; (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic test_i,
  input wire logic [5:0] low_cnt_i,
  input wire logic power_down_request_i,
  // pins towards the device
  output logic [NAND_W-1:0] pins_o
);
  logic tg_q;
  logic armed_q;
  initial begin
    tg_q = 1'b0;
    armed_q = 1'b0;
    pins_o = '1;
  end
  always @(posedge clk_i) begin
    tg_q <= !tg_q;
    // test-mode outputs driven only once reset has been held low
    armed_q <= !pins_o[NAND_IDX_RST];
    for (int k = 1; k < NAND_W; k++) begin
      if (test_i && armed_q) begin
        pins_o[k] <= (k > int'(low_cnt_i));
      end else begin
        // released lines wander, never hold the last level, except power-down, which follows its request outside test mode
        pins_o[k] <= tg_q ^ (k % 2 == 1);
      end
    end
    pins_o[NAND_IDX_RST] <= !test_i;
    if (!test_i) begin
      pins_o[NAND_IDX_POWER_DOWN] <= power_down_request_i;
    end
  end
endmodule // spt_tester

// ### tb/tb.sv
`timescale 1ns/100ps
module tb import spt_pkg::*;;
  localparam int unsigned RST_LEN = 20;
  // scaled stand-in for the idle time before the bus counts as free
  localparam int IDLE_LEN = 8;
  logic clk_i, resetn_i, awv, wv, bready, arv, rready, bsy, test;
  logic power_down_request;
  bit clk_stop;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [5:0] low_cnt;
  logic [1:0] r;
  logic [NAND_W-1:0] pins;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, rst_o, disc, bufen, drv_en;
  logic busy_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0, compares = 0, cyc_cnt = 0;
  int run = 0, rst_len = 0, disc_cnt = 0, idle_run = 0;

  spt_scsi_pwr #(.BUS_RST_CYCLES_P(RST_LEN)) spt_scsi_pwr_i (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .scsi_bsy_i(bsy), .scsi_rst_o(rst_o),
    .scsi_force_disc_o(disc), .scsi_in_buf_en_o(bufen),
    .pci_pins_i(pins), .pci_drive_en_o(drv_en),
    .busy_n_o(busy_n), .irq_o(irq));

  spt_tester spt_tester_i (.clk_i(clk_i), .test_i(test),
    .low_cnt_i(low_cnt), .power_down_request_i(power_down_request),
    .pins_o(pins));

  // ===========================================================
  // clock, watchdog, reset pulse monitor
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = clk_stop ? 1'b0 : ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      give_verdict();
    end
    if (disc === 1'b1) disc_cnt++;
    if (busy_n === 1'b1) idle_run++;
    else idle_run = 0;
    if (rst_o === 1'b1) begin
      run++;
    end else if (run != 0) begin
      rst_len = run;
      run = 0;
    end
  end

  // ===========================================================
  // helpers
  task automatic give_verdict();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge clk_i);
    awv <= 1'b1;
    awaddr <= a;
    wv <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk_i);
      if (aw && awrdy === 1'b1) begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (w && wrdy === 1'b1) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    r = bresp;
    bready <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    arv <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk_i); while (arrdy !== 1'b1);
    arv <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    #1;
  endtask
  function automatic logic exp_tree(input int n);
    if (n == 0) return 1'b1;
    if (n < 3) return 1'b0;
    return ((n - 3) % 2 == 0);
  endfunction

  // ===========================================================
  // main sequence
  initial begin
    resetn_i = 1'b0;
    {awv, wv, bready, arv, rready, bsy, test, power_down_request} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    low_cnt = '0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(2);
    rd(ADDR_CTRL_FOUR);
    chk("ctrl_four", d, {24'h0, CTRL_FOUR_RST});
    rd(ADDR_INT_MASK);
    chk("int_mask", d, {30'h0, INT_MASK_RST});
    rd(8'h10);
    chk("unmapped_rresp", r, RESP_SLVERR);
    chk("unmapped_rdata", d, 32'h0);
    wr(8'h10, 32'hFF);
    chk("unmapped_bresp", r, RESP_SLVERR);
    // bus must look idle long enough before the buffers go off
    while (idle_run < IDLE_LEN) cyc(1);
    wr(ADDR_CTRL_FOUR, 32'h20);
    chk("buf_en_off", bufen, 1'b0);
    rd(ADDR_CTRL_FOUR);
    chk("ctrl_four", d, 32'h20);
    clk_stop = 1'b1;
    #500;
    clk_stop = 1'b0;
    cyc(2);
    rd(ADDR_CTRL_FOUR);
    chk("ctrl_four_kept", d, 32'h20);
    wr(ADDR_CTRL_FOUR, 32'h0);
    chk("buf_en_on", bufen, 1'b1);
    wstrb <= 4'h0;
    wr(ADDR_CTRL_FOUR, 32'h20);
    chk("nostrb_bresp", r, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_CTRL_FOUR);
    chk("nostrb_ctrl_four", d, 32'h0);
    bsy <= 1'b1;
    cyc(3);
    chk("busy_n_bsy", busy_n, 1'b0);
    bsy <= 1'b0;
    cyc(3);
    chk("busy_n_idle", busy_n, 1'b1);
    wr(ADDR_INT_MASK, 32'h3);
    power_down_request <= 1'b1;
    cyc(4);
    rd(ADDR_DMA_STATUS);
    chk("pd_status", d & 32'h1, 32'h1);
    rd(ADDR_INT_STATUS);
    chk("pd_event", d, 32'h1);
    chk("irq_pd", irq, 1'b1);
    wr(ADDR_INT_STATUS, 32'h1);
    cyc(4);
    rd(ADDR_INT_STATUS);
    chk("pd_no_refire", d, 32'h0);
    chk("irq_cleared", irq, 1'b0);
    power_down_request <= 1'b0;
    cyc(3);
    wr(ADDR_DMA_STATUS, 32'h1);
    rd(ADDR_DMA_STATUS);
    chk("pd_status_clr", d & 32'h1, 32'h0);
    wr(ADDR_INT_MASK, 32'h0);
    power_down_request <= 1'b1;
    cyc(4);
    chk("irq_masked", irq, 1'b0);
    wr(ADDR_INT_STATUS, 32'h1);
    power_down_request <= 1'b0;
    wr(ADDR_INT_MASK, 32'h3);
    wr(ADDR_CMD, {24'h0, CMD_BUS_RESET});
    chk("scsi_rst", rst_o, 1'b1);
    rd(ADDR_DMA_STATUS);
    chk("rst_active", d & 32'h2, 32'h2);
    cyc(25);
    chk("rst_len", rst_len, RST_LEN);
    chk("disc_cnt", disc_cnt, 1);
    rd(ADDR_INT_STATUS);
    chk("rst_event", d, 32'h2);
    wr(ADDR_INT_STATUS, 32'h3);
    wr(ADDR_CTRL_ONE, 32'h40);
    wr(ADDR_CMD, {24'h0, CMD_BUS_RESET});
    cyc(25);
    rd(ADDR_INT_STATUS);
    chk("rst_event_off", d, 32'h0);
    chk("irq_none", irq, 1'b0);
    chk("disc_cnt2", disc_cnt, 2);
    test <= 1'b1;
    cyc(2);
    for (int n = 0; n < NAND_W; n++) begin
      low_cnt <= 6'(n);
      cyc(3);
      chk("tree_out", busy_n, exp_tree(n));
    end
    chk("drive_off", drv_en, 1'b0);
    test <= 1'b0;
    low_cnt <= '0;
    cyc(3);
    chk("drive_on", drv_en, 1'b1);
    chk("busy_n_norm", busy_n, 1'b1);
    give_verdict();
  end
endmodule // tb

// ### verilog/spt_nand_tree.sv
`timescale 1ns/100ps
module spt_nand_tree import spt_pkg::*; (
  // chain inputs, bit k is input k+1
  input wire logic [NAND_W-1:0] pins_i,
  // chain result
  output logic tree_o
);

  logic [NAND_W-1:0] stage;

  // ===========================================================
  // leaf: reset pin inverted, int a and int b share the first gate
  assign stage[NAND_IDX_RST] = ~pins_i[NAND_IDX_RST];
  assign stage[NAND_IDX_INTA] = ~(stage[NAND_IDX_RST]
      & pins_i[NAND_IDX_INTA] & pins_i[NAND_IDX_INTB]);
  assign stage[NAND_IDX_INTB] = stage[NAND_IDX_INTA];

  // ===========================================================
  // remaining inputs, clock first, power-down last
  for (genvar k = NAND_IDX_CLK; k < NAND_W; k++) begin : g_chain
    assign stage[k] = ~(stage[k-1] & pins_i[k]);
  end

  assign tree_o = stage[NAND_W-1];

endmodule // spt_nand_tree

// ### verilog/spt_pkg.sv
package spt_pkg;

  // ===========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned BUS_RST_MS = 25;
  localparam int unsigned BUS_RST_CYCLES = CLK_FREQ_HZ / 1000 * BUS_RST_MS;
  localparam int RST_CNT_W = 20;

  // ===========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_FOUR = 8'h34;
  localparam logic [7:0] ADDR_DMA_STATUS = 8'h54;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h58;
  localparam logic [7:0] ADDR_INT_MASK = 8'h5C;

  localparam logic [7:0] CMD_BUS_RESET = 8'h03;
  localparam int CTRL_ONE_RST_IRQ_DIS = 6;
  localparam int CTRL_FOUR_BUF_OFF = 5;
  localparam int DMA_PD_BIT = 0;
  localparam int DMA_RST_ACT_BIT = 1;
  localparam int INT_W = 2;

  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_FOUR_RST = 8'h00;
  localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================
  // test chain positions (bit k is chain input k+1)
  localparam int NAND_W = 56;
  localparam int NAND_IDX_RST = 0;
  localparam int NAND_IDX_INTA = 1;
  localparam int NAND_IDX_INTB = 2;
  localparam int NAND_IDX_CLK = 3;
  localparam int NAND_IDX_POWER_DOWN = 55;

  // ===========================================================
  // types
  typedef enum logic {ST_IDLE, ST_BUS_RST} spt_state_t;

  typedef struct packed {
    logic rst_evt;
    logic pd_evt;
  } spt_evt_t;

endpackage

// ### verilog/spt_scsi_pwr.sv
`timescale 1ns/100ps
module spt_scsi_pwr import spt_pkg::*; #(
  parameter int unsigned BUS_RST_CYCLES_P = BUS_RST_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  // axi4-lite write data
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read address
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  // axi4-lite read data
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // scsi side
  input wire logic scsi_bsy_i,
  output logic scsi_rst_o,
  output logic scsi_force_disc_o,
  output logic scsi_in_buf_en_o,
  // pci pins in chain order, power-down request last
  input wire logic [NAND_W-1:0] pci_pins_i,
  output logic pci_drive_en_o,
  // activity and interrupt
  output logic busy_n_o,
  output logic irq_o
);

  localparam logic [RST_CNT_W-1:0] RST_LAST =
      RST_CNT_W'(BUS_RST_CYCLES_P - 1);

  // ===========================================================
  // bus slave and register state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic wlane0_q, wlane0_d, awready_q, awready_d;
  logic wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic pd_stat_q, pd_stat_d, irq_q, irq_d, cmd_go, pd_clr;
  logic [7:0] awaddr_q, awaddr_d, ctrl_one_q, ctrl_one_d;
  logic [7:0] ctrl_four_q, ctrl_four_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [INT_W-1:0] int_mask_q, int_mask_d, int_clr;
  spt_evt_t int_stat_q, int_stat_d, evt;

  // ===========================================================
  // core state
  spt_state_t state_q, state_d;
  logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic scsi_rst_q, scsi_rst_d, disc_q, disc_d;
  logic busy_n_q, busy_n_d, drive_en_q, drive_en_d;
  logic buf_en_q, buf_en_d;
  logic test_mode, power_down_request, nand_out, bus_in_use;

  assign test_mode = ~pci_pins_i[NAND_IDX_RST];
  assign power_down_request = pci_pins_i[NAND_IDX_POWER_DOWN];
  assign bus_in_use = scsi_bsy_i | scsi_rst_q;

  spt_nand_tree u_tree (
    .pins_i(pci_pins_i),
    .tree_o(nand_out)
  );

  // ===========================================================
  // register next state
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d = awaddr_q;
    w_hold_d = w_hold_q;
    wdata_d = wdata_q;
    wlane0_d = wlane0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_one_d = ctrl_one_q;
    ctrl_four_d = ctrl_four_q;
    int_mask_d = int_mask_q;
    cmd_go = 1'b0;
    pd_clr = 1'b0;
    int_clr = '0;
    if (s_axi_awvalid_i && awready_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wlane0_d = s_axi_wstrb_i[0];
    end
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awaddr_q)
        ADDR_CMD: begin
          cmd_go = wlane0_q && (wdata_q[7:0] == CMD_BUS_RESET);
        end
        ADDR_CTRL_ONE: if (wlane0_q) ctrl_one_d = wdata_q[7:0];
        ADDR_CTRL_FOUR: if (wlane0_q) ctrl_four_d = wdata_q[7:0];
        ADDR_DMA_STATUS: pd_clr = wlane0_q && wdata_q[DMA_PD_BIT];
        ADDR_INT_STATUS: if (wlane0_q) int_clr = wdata_q[INT_W-1:0];
        ADDR_INT_MASK: if (wlane0_q) int_mask_d = wdata_q[INT_W-1:0];
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
    // power-down status: pin sets, write-one clears, set wins
    pd_stat_d = (pd_stat_q && !pd_clr) || power_down_request;
    evt.pd_evt = pd_stat_d && !pd_stat_q;
    evt.rst_evt = cmd_go && (state_q == ST_IDLE)
        && !ctrl_one_q[CTRL_ONE_RST_IRQ_DIS];
    int_stat_d = (int_stat_q & ~int_clr) | evt;
    irq_d = |(int_stat_d & int_mask_d);
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid_i && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case (s_axi_araddr_i)
        ADDR_CMD: rdata_d = '0;
        ADDR_CTRL_ONE: rdata_d[7:0] = ctrl_one_q;
        ADDR_CTRL_FOUR: rdata_d[7:0] = ctrl_four_q;
        ADDR_DMA_STATUS: begin
          rdata_d[DMA_PD_BIT] = pd_stat_q;
          rdata_d[DMA_RST_ACT_BIT] = scsi_rst_q;
        end
        ADDR_INT_STATUS: rdata_d[INT_W-1:0] = int_stat_q;
        ADDR_INT_MASK: rdata_d[INT_W-1:0] = int_mask_q;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wlane0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      ctrl_one_q <= CTRL_ONE_RST;
      ctrl_four_q <= CTRL_FOUR_RST;
      pd_stat_q <= 1'b0;
      int_stat_q <= '0;
      int_mask_q <= INT_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      awaddr_q <= awaddr_d;
      w_hold_q <= w_hold_d;
      wdata_q <= wdata_d;
      wlane0_q <= wlane0_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_one_q <= ctrl_one_d;
      ctrl_four_q <= ctrl_four_d;
      pd_stat_q <= pd_stat_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      irq_q <= irq_d;
    end
  end

  // ===========================================================
  // bus reset sequencer and pin steering
  always_comb begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_go) begin
          state_d = ST_BUS_RST;
          rst_cnt_d = '0;
        end
      end
      ST_BUS_RST: begin
        if (rst_cnt_q == RST_LAST) begin
          state_d = ST_IDLE;
        end else begin
          rst_cnt_d = rst_cnt_q + 1'b1;
        end
      end
    endcase
    scsi_rst_d = (state_d == ST_BUS_RST);
    disc_d = cmd_go && (state_q == ST_IDLE);
    busy_n_d = test_mode ? nand_out : !bus_in_use;
    drive_en_d = !test_mode;
    buf_en_d = !ctrl_four_q[CTRL_FOUR_BUF_OFF];
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      rst_cnt_q <= '0;
      scsi_rst_q <= 1'b0;
      disc_q <= 1'b0;
      busy_n_q <= 1'b1;
      drive_en_q <= 1'b0;
      buf_en_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
      scsi_rst_q <= scsi_rst_d;
      disc_q <= disc_d;
      busy_n_q <= busy_n_d;
      drive_en_q <= drive_en_d;
      buf_en_q <= buf_en_d;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign scsi_rst_o = scsi_rst_q;
  assign scsi_force_disc_o = disc_q;
  assign scsi_in_buf_en_o = buf_en_q;
  assign pci_drive_en_o = drive_en_q;
  assign busy_n_o = busy_n_q;
  assign irq_o = irq_q;

  // ===========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic [RST_CNT_W:0] rst_len_q;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !scsi_rst_o) begin
      rst_len_q <= '0;
    end else begin
      rst_len_q <= rst_len_q + 1'b1;
    end
  end

  sequence s_rst_cmd;
    cmd_go && (state_q == ST_IDLE);
  endsequence

  sequence s_rst_started;
    scsi_rst_o && scsi_force_disc_o ##1 scsi_rst_o && !scsi_force_disc_o;
  endsequence

  AST_RST_START: assert property (s_rst_cmd |=> s_rst_started)
    else $error("bus reset did not start with disconnect");
  AST_RST_LEN: assert property ($fell(scsi_rst_o) |->
      rst_len_q == (RST_CNT_W + 1)'(BUS_RST_CYCLES_P))
    else $error("bus reset length wrong");
  AST_RST_IRQ: assert property ($rose(int_stat_q.rst_evt) |->
      $past(cmd_go) && !$past(ctrl_one_q[CTRL_ONE_RST_IRQ_DIS]))
    else $error("reset interrupt without enabled command");
  AST_RST_NO_DONE_IRQ: assert property ($fell(scsi_rst_o) |->
      !$rose(int_stat_q.rst_evt))
    else $error("interrupt raised at bus reset completion");
  AST_BUSY_NORMAL: assert property (!test_mode && $past(!test_mode) |->
      busy_n_o == !$past(bus_in_use))
    else $error("activity pin does not follow bus use");
  AST_BUSY_TEST: assert property ($past(test_mode) |->
      busy_n_o == $past(nand_out))
    else $error("activity pin does not show chain result");
  AST_SWITCH: assert property ($changed(test_mode) |=>
      busy_n_o == (test_mode ? $past(nand_out) : !$past(bus_in_use)))
    else $error("activity source did not switch");
  AST_DRIVE_OFF: assert property (test_mode |=> !pci_drive_en_o)
    else $error("pci pins still driven in test mode");
  AST_BUF_OFF: assert property (ctrl_four_q[CTRL_FOUR_BUF_OFF] |=>
      !scsi_in_buf_en_o)
    else $error("input buffers not turned off");
  AST_PD_SET: assert property (power_down_request |=> pd_stat_q)
    else $error("power-down status not set");
  AST_PD_IRQ: assert property ($rose(int_stat_q.pd_evt) |->
      $rose(pd_stat_q))
    else $error("power-down interrupt without new status");
  AST_NAND_START: assert property (pci_pins_i ==
      {{(NAND_W-1){1'b1}}, 1'b0} |-> nand_out)
    else $error("chain start level not high");
  AST_NAND_INTA: assert property (pci_pins_i ==
      {{(NAND_W-2){1'b1}}, 2'h0} |-> !nand_out)
    else $error("chain not low after int a");
  AST_NAND_CLK: assert property (pci_pins_i ==
      {{(NAND_W-4){1'b1}}, 4'h0} |-> nand_out)
    else $error("chain not high after clock");
  AST_NAND_ALL: assert property (pci_pins_i == '0 |-> nand_out)
    else $error("chain not high with all inputs low");

endmodule // spt_scsi_pwr
